/* common/isc_pkg.sv */
// Purpose: shared constants and types for the start/collision block
// Assumes: baud reload field is seven bits wide
// Notes: state codes are Gray along the normal start path
package isc_pkg;
    localparam int BAUD_W = 7;
    localparam logic [BAUD_W-1:0] BAUD_ZERO = 7'h00;
    localparam logic [BAUD_W-1:0] BAUD_ONE = 7'h01;
    localparam logic LINE_LOW = 1'b0;
    localparam logic LINE_HIGH = 1'b1;
    localparam logic [1:0] SYNC_RST = 2'h0;
    localparam logic [1:0] LINE_RST = 2'h3;

    typedef enum logic [2:0] {
        ISC_IDLE = 3'h0,
        ISC_CHECK = 3'h1,
        ISC_COUNT1 = 3'h3,
        ISC_COUNT2 = 3'h2,
        ISC_HELD = 3'h6
    } isc_state_t;
endpackage

/* core/isc_start_gen.sv */
// Summary of operation
// - either line low at start: collision
// - clock low before data driven: collision
// - collision aborts, flags, resets serial module
// - data high: load counter from reload[6:0]
// - clock low, data high, first count: collision
// - data low in first count: drive early
// - count ends high: drive data low
// - reload; clock low now ignored
// - second count end drives clock low
// - simultaneous starts are not collisions
// Purpose: start condition generator with bus collision detection
// Assumes: link_clk_i runs freely; tick_i is one sys cycle wide
// Notes: lines are open drain, the pin outputs are always low
`timescale 1ns/100ps
module isc_start_gen (
    input wire logic sys_clk_i,
    input wire logic nrst_i,
    input wire logic link_clk_i,
    input wire logic start_req_i,
    input wire logic release_i,
    input wire logic tick_i,
    input wire logic [isc_pkg::BAUD_W-1:0] baud_reload_value_i,
    input wire logic flag_clear_i,
    input wire logic sda_i,
    input wire logic scl_i,
    output logic sda_o,
    output logic sda_oe_o,
    output logic scl_o,
    output logic scl_oe_o,
    output logic bus_collision_flag_o,
    output logic serial_port_module_reset_o,
    output logic start_done_o,
    output logic busy_o
);
    import isc_pkg::*;

    // ****************************************************************
    // link domain state
    // ****************************************************************
    typedef struct packed {
        logic [1:0] rst_sync;
        logic sda_oe;
        logic scl_oe;
        logic sda_out;
        logic scl_out;
    } isc_link_t;

    // ****************************************************************
    // system domain state
    // ****************************************************************
    typedef struct packed {
        isc_state_t state;
        logic [BAUD_W-1:0] baud_down_counter;
        logic sda_drv;
        logic scl_drv;
        logic flag;
        logic mod_rst;
        logic done;
        logic busy;
    } isc_sys_t;

    isc_link_t link_reg;
    isc_link_t link_next;
    isc_sys_t sys_reg;
    isc_sys_t sys_next;
    logic sda_hi;
    logic scl_hi;
    logic collide;
    logic link_nrst;
    logic link_sda;
    logic link_scl;
    logic link_sda_drv;
    logic link_scl_drv;
    logic sys_sda;
    logic sys_scl;

    // ****************************************************************
    // link side: sample pins, drive enables
    // ****************************************************************
    always_comb begin
        link_next = link_reg;
        // reset level crossed into the link clock
        link_next.rst_sync = {link_reg.rst_sync[0], nrst_i};
        link_next.sda_oe = link_sda_drv;
        link_next.scl_oe = link_scl_drv;
        // open drain: the level never moves, only the enables do
        link_next.sda_out = LINE_LOW;
        link_next.scl_out = LINE_LOW;
        if (!link_nrst) begin
            link_next.sda_oe = 1'h0;
            link_next.scl_oe = 1'h0;
        end
    end

    always_ff @(posedge link_clk_i) begin
        link_reg <= link_next;
    end

    assign link_nrst = link_reg.rst_sync[1];

    // ****************************************************************
    // synchronisers between pins, link clock and system clock
    // ****************************************************************
    // a pin crosses four flops, so collisions are seen a little late
    isc_sync2 #(
        .RST_VAL(LINE_RST)
    ) u_sda_pin_sync (
        .clk_i(link_clk_i),
        .nrst_i(link_nrst),
        .d_i(sda_i),
        .q_o(link_sda)
    );

    isc_sync2 #(
        .RST_VAL(LINE_RST)
    ) u_scl_pin_sync (
        .clk_i(link_clk_i),
        .nrst_i(link_nrst),
        .d_i(scl_i),
        .q_o(link_scl)
    );

    isc_sync2 #(
        .RST_VAL(SYNC_RST)
    ) u_sda_drv_sync (
        .clk_i(link_clk_i),
        .nrst_i(link_nrst),
        .d_i(sys_reg.sda_drv),
        .q_o(link_sda_drv)
    );

    isc_sync2 #(
        .RST_VAL(SYNC_RST)
    ) u_scl_drv_sync (
        .clk_i(link_clk_i),
        .nrst_i(link_nrst),
        .d_i(sys_reg.scl_drv),
        .q_o(link_scl_drv)
    );

    isc_sync2 #(
        .RST_VAL(LINE_RST)
    ) u_sda_sys_sync (
        .clk_i(sys_clk_i),
        .nrst_i(nrst_i),
        .d_i(link_sda),
        .q_o(sys_sda)
    );

    isc_sync2 #(
        .RST_VAL(LINE_RST)
    ) u_scl_sys_sync (
        .clk_i(sys_clk_i),
        .nrst_i(nrst_i),
        .d_i(link_scl),
        .q_o(sys_scl)
    );

    // ****************************************************************
    // start sequencer
    // ****************************************************************
    always_comb begin
        sys_next = sys_reg;
        sda_hi = (sys_sda == LINE_HIGH);
        scl_hi = (sys_scl == LINE_HIGH);
        collide = 1'b0;
        sys_next.mod_rst = 1'b0;
        sys_next.done = 1'b0;
        case (sys_reg.state)
            ISC_IDLE: begin
                if (start_req_i) begin
                    // both lines released when the start begins
                    sys_next.sda_drv = 1'b0;
                    sys_next.scl_drv = 1'b0;
                    sys_next.state = ISC_CHECK;
                end
            end
            ISC_CHECK: begin
                if (!sda_hi || !scl_hi) begin
                    collide = 1'b1;
                end else begin
                    sys_next.baud_down_counter = baud_reload_value_i;
                    sys_next.state = ISC_COUNT1;
                end
            end
            ISC_COUNT1: begin
                if (!scl_hi && sda_hi) begin
                    // another master is driving a one
                    collide = 1'b1;
                end else if (!sda_hi) begin
                    // a rival start already pulled data low; arbitration
                    // of the address decides, so no collision here
                    sys_next.sda_drv = 1'b1;
                    sys_next.baud_down_counter = baud_reload_value_i;
                    sys_next.state = ISC_COUNT2;
                end else if (tick_i) begin
                    if (sys_reg.baud_down_counter == BAUD_ZERO) begin
                        sys_next.sda_drv = 1'b1;
                        sys_next.baud_down_counter = baud_reload_value_i;
                        sys_next.state = ISC_COUNT2;
                    end else begin
                        sys_next.baud_down_counter =
                            sys_reg.baud_down_counter - BAUD_ONE;
                    end
                end
            end
            ISC_COUNT2: begin
                // clock low here is not checked on purpose
                if (tick_i) begin
                    if (sys_reg.baud_down_counter == BAUD_ZERO) begin
                        sys_next.scl_drv = 1'b1;
                        sys_next.done = 1'b1;
                        sys_next.state = ISC_HELD;
                    end else begin
                        sys_next.baud_down_counter =
                            sys_reg.baud_down_counter - BAUD_ONE;
                    end
                end
            end
            ISC_HELD: begin
                // the port logic takes over the lines from here
                if (release_i) begin
                    sys_next.sda_drv = 1'b0;
                    sys_next.scl_drv = 1'b0;
                    sys_next.state = ISC_IDLE;
                end
            end
            default: begin
                sys_next.state = ISC_IDLE;
            end
        endcase
        if (collide) begin
            sys_next.sda_drv = 1'b0;
            sys_next.scl_drv = 1'b0;
            sys_next.mod_rst = 1'b1;
            sys_next.state = ISC_IDLE;
        end
        // a new collision wins over a clear in the same cycle
        if (flag_clear_i) begin
            sys_next.flag = 1'b0;
        end
        if (collide) begin
            sys_next.flag = 1'b1;
        end
        sys_next.busy = (sys_next.state != ISC_IDLE);
        if (!nrst_i) begin
            sys_next.state = ISC_IDLE;
            sys_next.baud_down_counter = BAUD_ZERO;
            sys_next.sda_drv = 1'b0;
            sys_next.scl_drv = 1'b0;
            sys_next.flag = 1'b0;
            sys_next.mod_rst = 1'b0;
            sys_next.done = 1'b0;
            sys_next.busy = 1'b0;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        sys_reg <= sys_next;
    end

    // ****************************************************************
    // outputs
    // ****************************************************************
    assign sda_o = link_reg.sda_out;
    assign scl_o = link_reg.scl_out;
    assign sda_oe_o = link_reg.sda_oe;
    assign scl_oe_o = link_reg.scl_oe;
    assign bus_collision_flag_o = sys_reg.flag;
    assign serial_port_module_reset_o = sys_reg.mod_rst;
    assign start_done_o = sys_reg.done;
    assign busy_o = sys_reg.busy;
endmodule

// ****************************************************************
// two flop synchroniser
// ****************************************************************
module isc_sync2 #(
    parameter logic [1:0] RST_VAL = isc_pkg::SYNC_RST
) (
    input wire logic clk_i,
    input wire logic nrst_i,
    input wire logic d_i,
    output logic q_o
);
    import isc_pkg::*;

    typedef struct packed {
        logic [1:0] stage;
    } isc_sync_t;

    isc_sync_t sync_reg;
    isc_sync_t sync_next;

    always_comb begin
        sync_next = sync_reg;
        // only the second stage leaves the chain
        sync_next.stage = {sync_reg.stage[0], d_i};
        if (!nrst_i) begin
            sync_next.stage = RST_VAL;
        end
    end

    always_ff @(posedge clk_i) begin
        sync_reg <= sync_next;
    end

    assign q_o = sync_reg.stage[1];
endmodule

/* verification/isc_bus_model.sv */
// Purpose: rival devices on the shared two-wire bus
// Assumes: pull-ups on both lines, open drain drivers
// Notes: a rival pulls a line low while the bench asks
`timescale 1ns/100ps
module isc_bus_model (
    input wire logic dut_sda_oe_i, input wire logic dut_scl_oe_i,
    input wire logic rival_sda_i, input wire logic rival_scl_i,
    output logic sda_line_o, output logic scl_line_o
);
    // released lines float high, never hold a stale level
    assign sda_line_o = !(dut_sda_oe_i || rival_sda_i);
    assign scl_line_o = !(dut_scl_oe_i || rival_scl_i);
endmodule

/* verification/isc_start_gen_sva.sv */
// Purpose: port checker for the start and collision block
// Assumes: link outputs are slow beside the system clock
// Notes: ticks counted while busy must reach the reload value plus one by done
`timescale 1ns/100ps
module isc_start_gen_sva (
    input wire logic sys_clk_i, input wire logic nrst_i,
    input wire logic start_req_i, input wire logic tick_i,
    input wire logic [isc_pkg::BAUD_W-1:0] baud_reload_value_i,
    input wire logic flag_clear_i, input wire logic busy_o,
    input wire logic sda_oe_o, input wire logic scl_oe_o,
    input wire logic bus_collision_flag_o, input wire logic start_done_o,
    input wire logic serial_port_module_reset_o
);
    import isc_pkg::*;
    logic [8:0] tick_cnt_reg;
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (!nrst_i);
    always_ff @(posedge sys_clk_i) begin
        if (!nrst_i || !busy_o) tick_cnt_reg <= 9'h000;
        else if (tick_i) tick_cnt_reg <= tick_cnt_reg + 9'h001;
    end
    sequence s_take; start_req_i && !busy_o; endsequence
    sequence s_clr; flag_clear_i ##1 !serial_port_module_reset_o; endsequence
    property p_take; s_take |=> busy_o; endproperty
    a_take: assert property (p_take) else $error("start ignored");
    property p_coll; serial_port_module_reset_o |-> bus_collision_flag_o
        && !busy_o; endproperty
    a_coll: assert property (p_coll) else $error("abort state");
    property p_pulse; serial_port_module_reset_o |=>
        !serial_port_module_reset_o && !start_done_o; endproperty
    a_pulse: assert property (p_pulse) else $error("reset pulse");
    property p_done; start_done_o |-> busy_o ##1 !start_done_o; endproperty
    a_done: assert property (p_done) else $error("done pulse");
    property p_keep; bus_collision_flag_o && !flag_clear_i |=>
        bus_collision_flag_o; endproperty
    a_keep: assert property (p_keep) else $error("flag lost");
    property p_clear; s_clr |-> !bus_collision_flag_o; endproperty
    a_clear: assert property (p_clear) else $error("flag kept");
    property p_ticks; start_done_o |-> tick_cnt_reg >=
        {2'b00, baud_reload_value_i} + 9'h001; endproperty
    a_ticks: assert property (p_ticks) else $error("count short");
    property p_order; $rose(scl_oe_o) |-> sda_oe_o; endproperty
    a_order: assert property (p_order) else $error("clock first");
endmodule
bind isc_start_gen isc_start_gen_sva u_sva (.sys_clk_i, .nrst_i,
    .start_req_i, .tick_i, .baud_reload_value_i, .flag_clear_i, .busy_o,
    .sda_oe_o, .scl_oe_o, .bus_collision_flag_o, .start_done_o,
    .serial_port_module_reset_o);

/* verification/isc_start_gen_tb.sv */
// Purpose: directed bench for the start and collision block
// Assumes: a tick every other system cycle
// Notes: link side resets itself from the crossed reset level
`timescale 1ns/100ps
module isc_start_gen_tb;
    import isc_pkg::*;
    logic sys_clk_i = 1'b0, link_clk_i = 1'b0, nrst_i = 1'b0, tick_i = 1'b0;
    logic start_req_i = 1'b0, release_i = 1'b0, flag_clear_i = 1'b0;
    logic rival_sda = 1'b0, rival_scl = 1'b0, sda_i, scl_i, sda_o, scl_o;
    logic sda_oe_o, scl_oe_o, bus_collision_flag_o, start_done_o, busy_o;
    logic serial_port_module_reset_o;
    logic [BAUD_W-1:0] baud_reload_value_i = BAUD_ZERO;
    int miscompares = 0, checks = 0;
    always #2 sys_clk_i = ~sys_clk_i;
    always #7.5 link_clk_i = ~link_clk_i;
    always @(posedge sys_clk_i) #1 tick_i = ~tick_i;
    isc_start_gen u_dut (.sys_clk_i, .nrst_i, .link_clk_i, .start_req_i,
        .release_i, .tick_i, .baud_reload_value_i, .flag_clear_i, .sda_i,
        .scl_i, .sda_o, .scl_o, .sda_oe_o, .scl_oe_o, .bus_collision_flag_o,
        .serial_port_module_reset_o, .start_done_o, .busy_o);
    isc_bus_model u_bus (.dut_sda_oe_i(sda_oe_o), .dut_scl_oe_i(scl_oe_o),
        .rival_sda_i(rival_sda), .rival_scl_i(rival_scl),
        .sda_line_o(sda_i), .scl_line_o(scl_i));
    task automatic chk(input logic ok, input string m);
        checks++;
        miscompares += !ok;
        if (!ok) $display("Error at %0t ns: %s", $time, m);
    endtask
    task automatic run(input logic [BAUD_W-1:0] n, input int ev,
                       input logic exp, input int lo, input int hi);
        int t = 0, c = 0;
        {rival_sda, rival_scl, baud_reload_value_i} = {ev == 4, ev == 5, n};
        repeat (29) @(posedge sys_clk_i);
        @(posedge sys_clk_i) #1 start_req_i = 1'b1;
        @(posedge sys_clk_i) #1 start_req_i = 1'b0;
        for (int i = 0; i < 3000 && c == 0; i++) begin
            @(posedge sys_clk_i) t += (tick_i === 1'b1);
            #0.5 c = (start_done_o | serial_port_module_reset_o) === 1'b1;
            #0.5 rival_sda |= (ev == 1 && i == 20);
            rival_scl |= (ev == 2 && i == 20) || (ev == 3 && sda_oe_o);
        end
        chk(serial_port_module_reset_o === exp, "outcome");
        chk(exp || (t >= lo && t <= hi), "ticks");
        repeat (20) @(posedge sys_clk_i);
        #1 chk({bus_collision_flag_o, busy_o, sda_oe_o, scl_oe_o} ===
            {exp, !exp, !exp, !exp}, "state");
        chk({sda_o, scl_o} === 2'h0, "pin level");
        {release_i, flag_clear_i, rival_sda, rival_scl} = 4'hC;
        @(posedge sys_clk_i) #1 {release_i, flag_clear_i} = 2'h0;
        repeat (20) @(posedge sys_clk_i);
        #1 chk({bus_collision_flag_o, busy_o, sda_oe_o, scl_oe_o} === 4'h0,
            "idle");
    endtask
    task automatic t_start_min();
        run(BAUD_ZERO, 0, 1'b0, 2, 4);
    endtask
    task automatic t_start_max();
        run(7'h7F, 0, 1'b0, 256, 258);
    endtask
    task automatic t_rival_start();
        run(7'h40, 1, 1'b0, 65, 129);
    endtask
    task automatic t_clock_clash();
        run(7'h40, 2, 1'b1, 0, 0);
    endtask
    // long second count so the rival clock low lands inside it
    task automatic t_clock_late();
        run(7'h40, 3, 1'b0, 130, 132);
    endtask
    task automatic t_data_busy();
        run(7'h08, 4, 1'b1, 0, 0);
    endtask
    task automatic t_clock_busy();
        run(7'h08, 5, 1'b1, 0, 0);
    endtask
    initial begin
        // link side keeps resetting until the released level crosses
        repeat (6) @(posedge sys_clk_i);
        #1 nrst_i = 1'b1;
        t_start_min();
        t_start_max();
        t_rival_start();
        t_clock_clash();
        t_clock_late();
        t_data_busy();
        t_clock_busy();
        print_verdict();
    end
    initial begin
        #60000;
        miscompares++;
        print_verdict();
    end
    task automatic print_verdict();
        if (miscompares == 0 && checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
endmodule
